// >>> hw/adcst_pkg.sv
package adcst_pkg;
  // Byte offsets on the host port.
  localparam logic [4:0] ADCST_OFF_RESULT_LO = 5'h00;
  localparam logic [4:0] ADCST_OFF_RESULT_HI = 5'h01;
  localparam logic [4:0] ADCST_OFF_RANGE = 5'h02;
  localparam logic [4:0] ADCST_OFF_SCAN_FIRST = 5'h04;
  localparam logic [4:0] ADCST_OFF_SCAN_LAST = 5'h05;
  localparam logic [4:0] ADCST_OFF_CONTROL = 5'h06;
  localparam logic [4:0] ADCST_OFF_STATUS = 5'h07;
  localparam logic [4:0] ADCST_OFF_CLR_IRQ = 5'h08;
  localparam logic [4:0] ADCST_OFF_CLR_FIFO = 5'h09;
  localparam logic [4:0] ADCST_OFF_OUT0_LO = 5'h0a;
  localparam logic [4:0] ADCST_OFF_OUT0_HI = 5'h0b;
  localparam logic [4:0] ADCST_OFF_OUT_CTRL = 5'h0e;
  // Control byte fields.
  localparam int ADCST_CTL_PROG = 0;
  localparam int ADCST_CTL_PACER = 1;
  localparam int ADCST_CTL_EXT = 2;
  localparam int ADCST_CTL_GATE = 3;
  localparam int ADCST_CTL_INTERRUPT_GENERATION_ENABLE = 4;
  localparam int ADCST_CTL_CAUSE = 5;
  localparam int ADCST_CTL_FIRST_COUNTER_CLOCK_SELECT = 6;
  localparam int ADCST_CTL_WIDTH = 7;
  // Calibration byte and output control byte fields.
  localparam int ADCST_CAL_BIT = 7;
  localparam int ADCST_OUT0_GATE_BIT = 3;
  // Range entry fields.
  localparam int ADCST_RNG_GAIN_LSB = 0;
  localparam int ADCST_RNG_UNI_BIT = 4;
  localparam int ADCST_RNG_DIFF_BIT = 5;
  // Status byte fields.
  localparam int ADCST_ST_EMPTY = 0;
  localparam int ADCST_ST_HALF = 1;
  localparam int ADCST_ST_FULL = 2;
  localparam int ADCST_ST_IRQ = 3;
  // Reset values.
  localparam logic [7:0] ADCST_CTRL_RST = 8'h00;
  localparam logic [3:0] ADCST_CHAN_RST = 4'h0;
  // Calibration routing codes.
  localparam logic [2:0] ADCST_ROUTE_PIN = 3'h0;
  localparam logic [2:0] ADCST_ROUTE_GND = 3'h1;
  localparam logic [2:0] ADCST_ROUTE_REF5 = 3'h2;
  localparam logic [2:0] ADCST_ROUTE_OUT0 = 3'h3;
  localparam logic [2:0] ADCST_ROUTE_OUT1 = 3'h4;
endpackage : adcst_pkg

// >>> hw/adcst_top.sv
`timescale 1ns/1ns
// Summary of operation
// RULE1: Offset 4 low nibble holds first scan channel; upper bits unused.
// RULE2: Offset 5 low nibble holds last scan channel; upper bits unused.
// RULE3: Writing offset 4 or 5 restarts the channel pointer at first channel.
// RULE4: Every trigger converts the current channel then advances the pointer.
// RULE5: Pointer steps first to last, returns to first, repeats forever.
// RULE6: If first exceeds last, pointer counts modulo sixteen through 15 to 0.
// RULE7: First channel field addresses range memory on range-code writes.
// RULE8: Host keeps first equal last and triggers off while writing ranges.
// RULE9: Either channel of a differential pair returns the differential result.
// RULE10: Multi-channel scans skip the odd partner of a differential pair.
// RULE11: Only even channels go differential; following odd one is unavailable.
// RULE12: Control bits 0 to 2 enable triggers; host enables one at most.
// RULE13: Control bit 3 lets the gate input gate the external trigger.
// RULE14: Bit 4 enables interrupts; bit 5 picks per conversion or half full.
// RULE15: Bit 6 selects counter 0 clock: internal fixed or external input.
// RULE16: Bit 7 selects 16-bit result or 12-bit result with channel tag.
// RULE17: Offset 7 bit 7 selects calibration routing of inputs 0, 2, 4, 6.
// RULE18: Reading offset 6 returns the last written control byte.
// RULE19: Offset 7 bits 0 to 2 read FIFO empty, half full, full.
// RULE20: Offset 7 bit 3 reads one while an interrupt is pending.
// RULE21: Writing offset 8 clears the interrupt; writing offset 9 empties FIFO.
// RULE22: Gating flag clear: written output code reaches converter at once.
// RULE23: Gating flag set: code held until host reads offset 10 or 11.
// RULE24: Offsets 10 and 11 hold output code, 12 or 16 bits, LSB first.
// RULE25: Program trigger enabled: any write to offset 0 starts a conversion.
// RULE26: Pacer enabled: each counter 2 output rising edge starts a conversion.
// RULE27: Range write stores gain bits 2..0, unipolar bit 4, differential bit 5.
// RULE28: FIFO depth is a parameter; half at depth/2, full at depth.
// RULE29: Each result enters the FIFO with its channel, in conversion order.
module adcst_top
  import adcst_pkg::*;
#(
  parameter int FIFO_DEPTH = 1024,
  parameter bit HIRES = 1'b1
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [4:0] i_addr,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_pacer_out,
  input wire logic i_ext_trig,
  input wire logic i_ext_gate,
  input wire logic i_conv_done,
  input wire logic [15:0] i_conv_data,
  output logic o_conv_start,
  output logic [3:0] o_conv_channel,
  output logic [2:0] o_conv_gain,
  output logic o_conv_unipolar,
  output logic o_conv_diff,
  output logic [2:0] o_cal_route,
  output logic o_cal_mode,
  output logic o_first_counter_clock_select,
  output logic o_irq,
  output logic [15:0] o_output0_code
);
  // Occupancy needs one bit more than the address to tell full from empty.
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam logic [AW:0] HALF_CNT = (AW + 1)'(FIFO_DEPTH / 2);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(FIFO_DEPTH);
  localparam logic [AW-1:0] LAST_IDX = (AW)'(FIFO_DEPTH - 1);

  typedef struct packed {
    logic [3:0] scan_first_channel;
    logic [3:0] scan_last_channel;
    logic [3:0] ptr;
    logic [7:0] ctrl;
    logic cal;
    logic [15:0][5:0] range_mem;
    logic [7:0] code_lo;
    logic [7:0] code_hi;
    logic output0_read_gated_load;
    logic [15:0] output0_code;
    logic [7:0] rdata;
    logic conv_start;
    logic [3:0] conv_chan;
    logic [2:0] conv_gain;
    logic conv_uni;
    logic conv_diff;
    logic [2:0] cal_route;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic irq;
    logic half_prev;
    logic [2:0] pacer_sync;
    logic [2:0] ext_sync;
    logic [1:0] gate_sync;
  } adcst_state_t;

  adcst_state_t s_q;
  adcst_state_t s_d;
  // The sample memory itself is not reset; only its pointers are.
  logic [19:0] fifo_mem [FIFO_DEPTH];
  logic [19:0] head;
  logic push;
  logic [19:0] push_word;

  assign head = fifo_mem[s_q.rd_ptr];

  always_comb begin
    logic wr;
    logic rd;
    logic trig;
    logic pop;
    logic clr;
    logic [3:0] cur;
    logic [3:0] nxt;
    logic [5:0] ent;
    logic [15:0] wr_code;
    logic [AW:0] cnt;
    logic half_now;
    wr = 1'b0;
    rd = 1'b0;
    trig = 1'b0;
    pop = 1'b0;
    clr = 1'b0;
    cur = 4'h0;
    nxt = 4'h0;
    ent = 6'h00;
    wr_code = 16'h0000;
    cnt = '0;
    half_now = 1'b0;
    push = 1'b0;
    push_word = 20'h00000;
    s_d = s_q;
    wr = i_wr_stb;
    rd = i_rd_stb;

    // Input pins pass two flip-flops; on the pacer and trigger pins a third stage feeds edge detection.
    s_d.pacer_sync = {s_q.pacer_sync[1:0], i_pacer_out};
    s_d.ext_sync = {s_q.ext_sync[1:0], i_ext_trig};
    s_d.gate_sync = {s_q.gate_sync[0], i_ext_gate};

    // Either scan-range write restarts the pointer at the first channel.
    if (wr && i_addr == ADCST_OFF_SCAN_FIRST) begin
      s_d.scan_first_channel = i_wdata[3:0]; // RULE1
      s_d.ptr = i_wdata[3:0]; // RULE3
    end
    if (wr && i_addr == ADCST_OFF_SCAN_LAST) begin
      s_d.scan_last_channel = i_wdata[3:0]; // RULE2
      s_d.ptr = s_q.scan_first_channel; // RULE3
    end
    if (wr && i_addr == ADCST_OFF_RANGE) begin
      // The entry lands at the first channel, so the host parks the scan there first.
      // RULE7 RULE27
      s_d.range_mem[s_q.scan_first_channel] = {i_wdata[ADCST_RNG_DIFF_BIT],
                                               i_wdata[ADCST_RNG_UNI_BIT],
                                               1'b0,
                                               i_wdata[ADCST_RNG_GAIN_LSB +: 3]};
      if (s_q.scan_first_channel[0]) begin
        s_d.range_mem[s_q.scan_first_channel][ADCST_RNG_DIFF_BIT] = 1'b0; // RULE11
      end
    end
    // Only bit 7 of the calibration byte and bit 3 of output control are kept.
    if (wr && i_addr == ADCST_OFF_CONTROL) begin
      s_d.ctrl = i_wdata; // RULE12
    end
    if (wr && i_addr == ADCST_OFF_STATUS) begin
      s_d.cal = i_wdata[ADCST_CAL_BIT] & HIRES; // RULE17
    end
    if (wr && i_addr == ADCST_OFF_OUT_CTRL) begin
      s_d.output0_read_gated_load = i_wdata[ADCST_OUT0_GATE_BIT];
    end

    // Output code: bytes assemble LSB first, narrowed on the 12-bit variant.
    wr_code = {s_q.code_hi, s_q.code_lo};
    if (wr && i_addr == ADCST_OFF_OUT0_LO) begin
      s_d.code_lo = i_wdata; // RULE24
      wr_code[7:0] = i_wdata;
    end
    if (wr && i_addr == ADCST_OFF_OUT0_HI) begin
      s_d.code_hi = i_wdata; // RULE24
      wr_code[15:8] = i_wdata;
    end
    // The narrow variant drops the top four code bits.
    if (!HIRES) begin
      wr_code[15:12] = 4'h0;
    end
    if (wr && (i_addr == ADCST_OFF_OUT0_LO || i_addr == ADCST_OFF_OUT0_HI) &&
        !s_q.output0_read_gated_load) begin
      s_d.output0_code = wr_code; // RULE22
    end
    if (rd && (i_addr == ADCST_OFF_OUT0_LO || i_addr == ADCST_OFF_OUT0_HI) &&
        s_q.output0_read_gated_load) begin
      s_d.output0_code = wr_code; // RULE23
    end

    // Trigger sources.
    if (wr && i_addr == ADCST_OFF_RESULT_LO && s_q.ctrl[ADCST_CTL_PROG]) begin
      trig = 1'b1; // RULE25
    end
    // Pin triggers act on the rising edge seen between the second and third stages.
    if (s_q.ctrl[ADCST_CTL_PACER] && s_q.pacer_sync[1] && !s_q.pacer_sync[2]) begin
      trig = 1'b1; // RULE26
    end
    if (s_q.ctrl[ADCST_CTL_EXT] && s_q.ext_sync[1] && !s_q.ext_sync[2] &&
        (!s_q.ctrl[ADCST_CTL_GATE] || s_q.gate_sync[1])) begin
      trig = 1'b1; // RULE13
    end

    // Conversion of the current channel, then pointer advance.
    s_d.conv_start = 1'b0;
    cur = s_q.ptr;
    if (cur[0] && s_q.range_mem[{cur[3:1], 1'b0}][ADCST_RNG_DIFF_BIT]) begin
      cur = {cur[3:1], 1'b0}; // RULE9
    end
    ent = s_q.range_mem[cur];
    if (s_q.ptr == s_q.scan_last_channel) begin
      nxt = s_q.scan_first_channel; // RULE5
    end else begin
      nxt = s_q.ptr + 4'h1; // RULE6
    end
    // A differential even channel takes one slot, so its odd partner is skipped.
    if (!s_q.ptr[0] && ent[ADCST_RNG_DIFF_BIT] &&
        s_q.scan_first_channel != s_q.scan_last_channel &&
        nxt == s_q.ptr + 4'h1) begin
      if (nxt == s_q.scan_last_channel) begin
        nxt = s_q.scan_first_channel; // RULE10
      end else begin
        nxt = s_q.ptr + 4'h2; // RULE10
      end
    end
    // A trigger in the cycle of a scan-range write is dropped so the restart is clean.
    if (trig && !(wr && (i_addr == ADCST_OFF_SCAN_FIRST ||
                         i_addr == ADCST_OFF_SCAN_LAST))) begin
      s_d.conv_start = 1'b1; // RULE4
      s_d.conv_chan = cur;
      s_d.conv_gain = ent[2:0];
      s_d.conv_uni = ent[ADCST_RNG_UNI_BIT];
      s_d.conv_diff = ent[ADCST_RNG_DIFF_BIT];
      s_d.ptr = nxt; // RULE4
      s_d.cal_route = ADCST_ROUTE_PIN;
      if (s_q.cal) begin
        case (cur)
          4'h0: s_d.cal_route = ADCST_ROUTE_GND; // RULE17
          4'h2: s_d.cal_route = ADCST_ROUTE_REF5;
          4'h4: s_d.cal_route = ADCST_ROUTE_OUT0;
          4'h6: s_d.cal_route = ADCST_ROUTE_OUT1;
          default: s_d.cal_route = ADCST_ROUTE_PIN;
        endcase
      end
    end

    // Result formatting and FIFO push.
    if (HIRES && !s_q.ctrl[ADCST_CTL_WIDTH]) begin
      push_word = {s_q.conv_chan, i_conv_data}; // RULE16
    end else begin
      push_word = {s_q.conv_chan, s_q.conv_chan, i_conv_data[11:0]}; // RULE16
    end
    // A clear and a push in one cycle leave the new word as the only entry.
    clr = wr && i_addr == ADCST_OFF_CLR_FIFO;
    pop = rd && i_addr == ADCST_OFF_RESULT_HI && s_q.count != '0 && !clr;
    cnt = s_q.count;
    if (clr) begin
      s_d.rd_ptr = '0; // RULE21
      s_d.wr_ptr = '0;
      cnt = '0;
    end
    if (pop) begin
      s_d.rd_ptr = (s_q.rd_ptr == LAST_IDX) ? '0 : s_q.rd_ptr + 1'b1;
      cnt = cnt - 1'b1;
    end
    if (i_conv_done && cnt != FULL_CNT) begin
      push = 1'b1; // RULE29
      s_d.wr_ptr = clr ? (AW)'(1) : ((s_q.wr_ptr == LAST_IDX) ? '0 : s_q.wr_ptr + 1'b1);
      cnt = cnt + 1'b1;
    end
    s_d.count = cnt;

    // Interrupt: a cause in the same cycle as a clear wins.
    // With bit 5 clear each completed conversion is a cause, even one that a full FIFO drops.
    half_now = s_d.count >= HALF_CNT; // RULE28
    s_d.half_prev = half_now;
    if (wr && i_addr == ADCST_OFF_CLR_IRQ) begin
      s_d.irq = 1'b0; // RULE21
    end
    if (s_q.ctrl[ADCST_CTL_INTERRUPT_GENERATION_ENABLE]) begin
      if (!s_q.ctrl[ADCST_CTL_CAUSE] && i_conv_done) begin
        s_d.irq = 1'b1; // RULE14
      end
      if (s_q.ctrl[ADCST_CTL_CAUSE] && half_now && !s_q.half_prev) begin
        s_d.irq = 1'b1; // RULE14
      end
    end

    // Read data.
    // Unmapped offsets and the output load strobes read as zero.
    s_d.rdata = 8'h00;
    if (rd) begin
      case (i_addr)
        ADCST_OFF_RESULT_LO: s_d.rdata = head[7:0];
        ADCST_OFF_RESULT_HI: s_d.rdata = head[15:8];
        ADCST_OFF_CONTROL: s_d.rdata = s_q.ctrl; // RULE18
        ADCST_OFF_STATUS: begin
          s_d.rdata[ADCST_CAL_BIT] = s_q.cal;
          s_d.rdata[ADCST_ST_EMPTY] = s_q.count == '0; // RULE19
          s_d.rdata[ADCST_ST_HALF] = s_q.count >= HALF_CNT; // RULE19
          s_d.rdata[ADCST_ST_FULL] = s_q.count == FULL_CNT; // RULE19
          s_d.rdata[ADCST_ST_IRQ] = s_q.irq; // RULE20
        end
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // Reset clears control, scan range, range memory and FIFO pointers.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      s_q <= '0;
      s_q.ctrl <= ADCST_CTRL_RST;
      s_q.scan_first_channel <= ADCST_CHAN_RST;
      s_q.scan_last_channel <= ADCST_CHAN_RST;
      s_q.ptr <= ADCST_CHAN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Sample storage, written in conversion order.
  always_ff @(posedge i_mclk) begin
    if (push) begin
      fifo_mem[(i_wr_stb && i_addr == ADCST_OFF_CLR_FIFO) ? '0 : s_q.wr_ptr] <= push_word;
    end
  end

  // Every output is taken straight from the state register.
  assign o_rdata = s_q.rdata;
  assign o_conv_start = s_q.conv_start;
  assign o_conv_channel = s_q.conv_chan;
  assign o_conv_gain = s_q.conv_gain;
  assign o_conv_unipolar = s_q.conv_uni;
  assign o_conv_diff = s_q.conv_diff;
  assign o_cal_route = s_q.cal_route;
  assign o_cal_mode = s_q.cal;
  assign o_first_counter_clock_select = s_q.ctrl[ADCST_CTL_FIRST_COUNTER_CLOCK_SELECT]; // RULE15
  assign o_irq = s_q.irq;
  assign o_output0_code = s_q.output0_code;
endmodule : adcst_top

// >>> dv/adcst_monitor.sv
`timescale 1ns/1ns
module adcst_monitor
  import adcst_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [4:0] i_addr,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic i_conv_done,
  input wire logic o_conv_start,
  input wire logic o_cal_mode,
  input wire logic o_first_counter_clock_select,
  input wire logic o_irq,
  input wire logic [15:0] o_output0_code
);
  logic [7:0] ctl_q;
  logic [7:0] hi_q;
  logic g_q;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      ctl_q <= 8'h00;
      g_q <= 1'b0;
    end else if (i_wr_stb) begin
      if (i_addr == ADCST_OFF_CONTROL) begin
        ctl_q <= i_wdata;
      end
      if (i_addr == ADCST_OFF_OUT_CTRL) begin
        g_q <= i_wdata[ADCST_OUT0_GATE_BIT];
      end
      if (i_addr == ADCST_OFF_OUT0_HI) begin
        hi_q <= i_wdata;
      end
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  a_prog_start: assert property (i_wr_stb && i_addr == ADCST_OFF_RESULT_LO && ctl_q[0]
    |=> o_conv_start) else $error("no start after program write");
  a_ctl_readback: assert property (i_rd_stb && i_addr == ADCST_OFF_CONTROL
    |=> o_rdata == $past(ctl_q)) else $error("control readback wrong");
  a_rdata_idle: assert property (!i_rd_stb |=> o_rdata == 8'h00) else $error("read data not idle");
  a_irq_clear: assert property (i_wr_stb && i_addr == ADCST_OFF_CLR_IRQ && !i_conv_done
    && !$past(i_conv_done) |=> !o_irq) else $error("interrupt not cleared");
  a_irq_enable: assert property ($rose(o_irq) |-> $past(ctl_q[ADCST_CTL_INTERRUPT_GENERATION_ENABLE]))
    else $error("interrupt while disabled");
  a_each_conv: assert property (ctl_q[4] && !ctl_q[5] && i_conv_done |=> o_irq)
    else $error("no interrupt on conversion");
  a_cal_reg: assert property (i_wr_stb && i_addr == ADCST_OFF_STATUS
    |=> o_cal_mode == $past(i_wdata[7])) else $error("calibration mode wrong");
  a_first_counter_clock_select_sel: assert property (i_wr_stb && i_addr == ADCST_OFF_CONTROL
    |=> o_first_counter_clock_select == $past(i_wdata[6])) else $error("counter clock wrong");
  a_gate_hold: assert property (g_q && $past(g_q) && !$past(i_rd_stb) && !$past(i_rd_stb, 2)
    |-> $stable(o_output0_code)) else $error("gated code moved");
  a_ungated_load: assert property (i_wr_stb && i_addr == ADCST_OFF_OUT0_HI && !g_q
    |=> ##[0:1] o_output0_code[15:8] == hi_q) else $error("code not loaded");
endmodule : adcst_monitor
bind adcst_top adcst_monitor u_mon (.*);

// >>> dv/testbench.sv
`timescale 1ns/1ns
module testbench
  import adcst_pkg::*;
;
  logic i_mclk = 1'b0, i_rst_b = 1'b0, i_wr_stb = 1'b0, i_rd_stb = 1'b0;
  logic i_pacer_out = 1'b0, i_ext_trig = 1'b0, i_ext_gate = 1'b0, i_conv_done = 1'b0;
  logic [4:0] i_addr = 5'h00;
  logic [7:0] i_wdata = 8'h00, o_rdata, rv, q, a8, b8;
  logic [15:0] i_conv_data = 16'h0000, o_output0_code, d0;
  logic o_conv_start, o_conv_unipolar, o_conv_diff, o_cal_mode, o_first_counter_clock_select, o_irq;
  logic [3:0] o_conv_channel, first, last, cur, lastch;
  logic [2:0] o_conv_gain, o_cal_route;
  logic diff [16];
  int err_count = 0, comparisons = 0, seed = 32'hf4f8;
  always #20 i_mclk = ~i_mclk;
  adcst_top #(.FIFO_DEPTH(8), .HIRES(1'b1)) uut (.*);
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (e !== g) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    i_addr = a;
    i_wdata = d;
    i_wr_stb = 1'b1;
    @(posedge i_mclk) #1;
    i_wr_stb = 1'b0;
    @(posedge i_mclk) #1;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] r);
    i_addr = a;
    i_rd_stb = 1'b1;
    @(posedge i_mclk) #1;
    i_rd_stb = 1'b0;
    r = o_rdata;
    @(posedge i_mclk) #1;
  endtask : rd
  task automatic push(input logic [15:0] d);
    i_conv_data = d;
    i_conv_done = 1'b1;
    @(posedge i_mclk) #1;
    i_conv_done = 1'b0;
    @(posedge i_mclk) #1;
  endtask : push
  function automatic logic [3:0] nxt(input logic [3:0] c);
    logic [3:0] n;
    n = (c == last) ? first : c + 4'h1;
    if (diff[c] && !c[0] && c != last && first != last) n = (c + 4'h1 == last) ? first : c + 4'h2;
    return n;
  endfunction : nxt
  task automatic set_scan(input logic [3:0] f, input logic [3:0] l);
    wr(ADCST_OFF_SCAN_FIRST, {4'h0, f});
    wr(ADCST_OFF_SCAN_LAST, {4'h0, l});
    first = f;
    last = l;
    cur = f;
  endtask : set_scan
  task automatic trig_scan(input int n);
    repeat (n) begin
      wr(ADCST_OFF_RESULT_LO, 8'($random(seed)));
      chk("channel", {12'h0, cur}, {12'h0, o_conv_channel});
      lastch = cur;
      cur = nxt(cur);
    end
  endtask : trig_scan
  task automatic wait_start(input logic e);
    logic s;
    s = 1'b0;
    repeat (12) begin
      @(posedge i_mclk) #1;
      s = s | o_conv_start;
    end
    chk("start", {15'h0, e}, {15'h0, s});
  endtask : wait_start
  task automatic conclude();
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (50000) @(posedge i_mclk);
    err_count++;
    conclude();
  end
  initial begin
    for (int i = 0; i < 16; i++) diff[i] = 1'b0;
    repeat (3) @(posedge i_mclk);
    #1;
    i_rst_b = 1'b1;
    rd(ADCST_OFF_STATUS, q);
    chk("status", 16'h01, {8'h0, q});
    for (int i = 0; i < 9; i++) begin
      rv = 8'($random(seed));
      rv[2:0] = 3'b001 << (i % 3);
      wr(ADCST_OFF_CONTROL, rv);
      rd(ADCST_OFF_CONTROL, q);
      chk("control", {8'h0, rv}, {8'h0, q});
      chk("first_counter_clock_select", {15'h0, rv[6]}, {15'h0, o_first_counter_clock_select});
    end
    wr(ADCST_OFF_CONTROL, 8'h00);
    set_scan(4'hd, 4'h2);
    wr(ADCST_OFF_CONTROL, 8'h01);
    trig_scan(8);
    wr(ADCST_OFF_SCAN_LAST, 8'hf2);
    cur = first;
    trig_scan(2);
    repeat (6) begin
      rv = 8'($random(seed));
      set_scan(rv[3:0], rv[7:4]);
      trig_scan(20);
    end
    wr(ADCST_OFF_CONTROL, 8'h00);
    set_scan(4'h3, 4'h3);
    wr(ADCST_OFF_RANGE, 8'h15);
    set_scan(4'h4, 4'h4);
    wr(ADCST_OFF_RANGE, 8'h20);
    diff[4] = 1'b1;
    set_scan(4'h3, 4'h7);
    wr(ADCST_OFF_CONTROL, 8'h01);
    trig_scan(1);
    chk("gain", 16'h5, {13'h0, o_conv_gain});
    chk("unipolar", 16'h1, {15'h0, o_conv_unipolar});
    trig_scan(6);
    set_scan(4'h5, 4'h5);
    wr(ADCST_OFF_RESULT_LO, 8'h00);
    chk("channel", 16'h4, {12'h0, o_conv_channel});
    chk("diff", 16'h1, {15'h0, o_conv_diff});
    lastch = 4'h4;
    wr(ADCST_OFF_CONTROL, 8'h30);
    wr(ADCST_OFF_CLR_FIFO, 8'h5a);
    for (int i = 0; i < 8; i++) begin
      rv = 8'($random(seed));
      if (i == 0) d0 = {rv, ~rv};
      push(i == 0 ? d0 : {rv, rv});
      rd(ADCST_OFF_STATUS, q);
      chk("status", (i >= 3 ? 16'h0a : 16'h00) | (i == 7 ? 16'h04 : 16'h00), {8'h0, q});
    end
    wr(ADCST_OFF_CLR_IRQ, 8'ha5);
    rd(ADCST_OFF_STATUS, q);
    chk("status", 16'h06, {8'h0, q});
    rd(ADCST_OFF_RESULT_LO, a8);
    rd(ADCST_OFF_RESULT_HI, b8);
    chk("result", d0, {b8, a8});
    wr(ADCST_OFF_CLR_FIFO, 8'h00);
    rd(ADCST_OFF_STATUS, q);
    chk("status", 16'h01, {8'h0, q});
    wr(ADCST_OFF_CONTROL, 8'h90);
    push(16'h0abc);
    rd(ADCST_OFF_STATUS, q);
    chk("status", 16'h08, {8'h0, q});
    chk("irq", 16'h1, {15'h0, o_irq});
    rd(ADCST_OFF_RESULT_LO, a8);
    rd(ADCST_OFF_RESULT_HI, b8);
    chk("tagged", {lastch, 12'habc}, {b8, a8});
    wr(ADCST_OFF_CLR_IRQ, 8'h00);
    wr(ADCST_OFF_STATUS, 8'h80);
    rd(ADCST_OFF_STATUS, q);
    chk("status", 16'h81, {8'h0, q});
    chk("calmode", 16'h1, {15'h0, o_cal_mode});
    wr(ADCST_OFF_CONTROL, 8'h01);
    set_scan(4'h2, 4'h2);
    wr(ADCST_OFF_RESULT_LO, 8'h00);
    chk("route", {13'h0, ADCST_ROUTE_REF5}, {13'h0, o_cal_route});
    wr(ADCST_OFF_STATUS, 8'h00);
    wr(ADCST_OFF_OUT_CTRL, 8'h00);
    a8 = 8'($random(seed));
    b8 = 8'($random(seed));
    wr(ADCST_OFF_OUT0_LO, a8);
    wr(ADCST_OFF_OUT0_HI, b8);
    chk("code", {b8, a8}, o_output0_code);
    wr(ADCST_OFF_OUT_CTRL, 8'h08);
    wr(ADCST_OFF_OUT0_LO, ~a8);
    wr(ADCST_OFF_OUT0_HI, ~b8);
    chk("code", {b8, a8}, o_output0_code);
    rd(ADCST_OFF_OUT0_LO, q);
    @(posedge i_mclk) #1;
    chk("code", {~b8, ~a8}, o_output0_code);
    wr(ADCST_OFF_CONTROL, 8'h02);
    i_pacer_out = 1'b1;
    wait_start(1'b1);
    i_pacer_out = 1'b0;
    wait_start(1'b0);
    wr(ADCST_OFF_CONTROL, 8'h0c);
    i_ext_trig = 1'b1;
    wait_start(1'b0);
    i_ext_trig = 1'b0;
    i_ext_gate = 1'b1;
    wait_start(1'b0);
    i_ext_trig = 1'b1;
    wait_start(1'b1);
    conclude();
  end
endmodule : testbench
